/* File: hw/led_seq_pkg.sv */
// Shared constants and carriers for the status indicator sequencer
package led_seq_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_MHZ = 200;
   localparam int ADDR_SHOW_MS = 2000;
   localparam int ADDR_SHOW_CYC = ADDR_SHOW_MS * 1000 * CLK_MHZ;
   localparam int STEP_MS = 100;
   localparam int STEP_CYC = STEP_MS * 1000 * CLK_MHZ;
   localparam int FLASH_HALF_MS = 250;
   localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;

   // ==========================================================
   // Geometry and reset values
   localparam int NUM_CH = 8;
   localparam logic [7:0] LED_OFF = 8'h00;
   localparam logic [7:0] LED_ALL = 8'hFF;

   // ==========================================================
   // Variants
   typedef enum logic [1:0] {
      VAR_IO = 2'h0,
      VAR_RELAY = 2'h1,
      VAR_ANALOG = 2'h2
   } variant_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic unconfigured;
      logic disabled;
      logic replace;
      logic watchdog_err;
      logic low_power;
   } dev_stat_t;

   typedef struct packed {
      logic [7:0] active;
      logic [7:0] supv_fault;
      logic [7:0] pos_drv_fail;
      logic [7:0] neg_drv_fail;
      logic [7:0] not_cfg;
      logic [7:0] low_alarm;
      logic [7:0] high_alarm;
      logic [7:0] out_of_range;
   } ch_stat_t;

   typedef struct packed {
      logic power;
      logic fault;
      logic [7:0] red;
      logic [7:0] yellow;
   } leds_t;

endpackage : led_seq_pkg

/* File: hw/tick_gen.sv */
// Free-running tick generator with a programmable period
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
   parameter int PERIOD = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Tick out
   output logic tick
);
   if (PERIOD < 2) begin : g_bad_period
      $error("tick_gen PERIOD must be at least 2");
   end

   localparam int W = $clog2(PERIOD);
   localparam logic [W-1:0] LAST = W'(PERIOD - 1);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic tick_q;
   logic tick_d;

   always_comb begin
      cnt_d = (cnt_q == LAST) ? '0 : cnt_q + W'(1);
      tick_d = (cnt_q == LAST);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule : tick_gen
`default_nettype wire

/* File: hw/sync2.sv */
// Two-flop synchroniser for a bus of levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   if (W < 1) begin : g_bad_width
      $error("sync2 W must be at least 1");
   end

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
      end
   end

   assign dout = s2_q;
endmodule : sync2
`default_nettype wire

/* File: hw/led_seq.sv */
// Front-panel status indicator sequencer for an eight-channel module
// Functional notes
// R1: Two device and sixteen channel indicators driven
// R2: Power-up lights power and fault together
// R3: Red indicators on, channel 1 to 8
// R4: Then red indicators off, 1 to 8
// R5: Same on/off sweep for yellow indicators
// R6: Red shows address switches, switch n channel n
// R7: Address pattern held two seconds
// R8: Fault indicator off after address display
// R9: Unconfigured: all yellow flash in unison; channels with a steady yellow fault stay lit
// R10: Supervised channel fault lights yellow, status
// R11: Failed driver test lights yellow, status
// R12: Power indicator lit while powered
// R13: Fault steady when disabled, replace, watchdog
// R14: Fault indicator blinks once at power-up
// R15: Relay variant: red steady when active
// R16: Yellow blinks on low power or misconfig
// R17: Analog variant: red blink low, steady high
// R18: Analog variant: yellow steady when out of range
// R19: Step and flash periods parameters, common phase
// R20: Address switches sampled once after reset
`timescale 1ns/1ps
`default_nettype none
module led_seq
   import led_seq_pkg::*;
#(
   parameter variant_t VARIANT = VAR_IO,
   parameter int STEP_CYCLES = STEP_CYC,
   parameter int FLASH_CYCLES = FLASH_HALF_CYC,
   parameter int ADDR_CYCLES = ADDR_SHOW_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Address switches from the panel
   input wire logic [7:0] addr_sw,
   // Status from the module logic
   input wire dev_stat_t dev_stat,
   input wire ch_stat_t ch_stat,
   // Indicators
   output leds_t leds,
   // Per-channel fault status parameter
   output logic [7:0] ch_fault_stat,
   // Power-up sequence finished
   output logic pu_done
);
   // Refuse periods, widths and variant codings the counters and ports cannot serve
   if (STEP_CYCLES < 2) begin : g_bad_step
      $error("STEP_CYCLES must be at least 2");
   end
   if (FLASH_CYCLES < 2) begin : g_bad_flash
      $error("FLASH_CYCLES must be at least 2");
   end
   if (ADDR_CYCLES < 2) begin : g_bad_addr
      $error("ADDR_CYCLES must be at least 2");
   end
   if (VARIANT != VAR_IO && VARIANT != VAR_RELAY && VARIANT != VAR_ANALOG) begin : g_bad_variant
      $error("VARIANT is not a known coding");
   end
   if (NUM_CH != 8) begin : g_bad_chans
      $error("NUM_CH must match the eight-bit channel ports");
   end

   // ==========================================================
   // Sequencer states
   typedef enum logic [6:0] {
      ST_LAMP = 7'h01,
      ST_RED_ON = 7'h02,
      ST_RED_OFF = 7'h04,
      ST_YEL_ON = 7'h08,
      ST_YEL_OFF = 7'h10,
      ST_ADDR = 7'h20,
      ST_RUN = 7'h40
   } state_t;

   localparam int AW = $clog2(ADDR_CYCLES + 1);
   localparam logic [AW-1:0] ADDR_LAST = AW'(ADDR_CYCLES - 1);
   localparam logic [2:0] CH_LAST = 3'h7;

   // Thermometer mask of channels 1..n+1 (index 0 is channel 1)
   function automatic logic [7:0] upto(input logic [2:0] idx);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < NUM_CH; i++) begin
         if (i <= int'(idx)) m[i] = 1'b1;
      end
      return m;
   endfunction : upto

   // ==========================================================
   // Switch sync and time bases
   logic [7:0] sw_sync;
   logic step_tick;
   logic flash_tick;

   sync2 #(.W(8)) u_sw_sync (
      .clk(clk),
      .srst(srst),
      .din(addr_sw),
      .dout(sw_sync)
   );

   // Single time base for every flashing indicator keeps them in phase
   tick_gen #(.PERIOD(STEP_CYCLES)) u_step (
      .clk(clk),
      .srst(srst),
      .tick(step_tick)
   ); // R19

   tick_gen #(.PERIOD(FLASH_CYCLES)) u_flash (
      .clk(clk),
      .srst(srst),
      .tick(flash_tick)
   ); // R19

   // ==========================================================
   // Flash phase
   logic phase_q;
   logic phase_d;

   always_comb begin
      phase_d = flash_tick ? ~phase_q : phase_q; // R19
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
      end
   end

   // ==========================================================
   // Address capture: switch value settles through the
   // synchroniser, so capture is taken two cycles after release
   logic [1:0] cap_cnt_q;
   logic [1:0] cap_cnt_d;
   logic [7:0] addr_q;
   logic [7:0] addr_d;

   always_comb begin
      cap_cnt_d = cap_cnt_q;
      addr_d = addr_q;
      if (cap_cnt_q != 2'h3) begin
         cap_cnt_d = cap_cnt_q + 2'h1;
      end
      if (cap_cnt_q == 2'h2) begin
         addr_d = sw_sync; // R20
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cap_cnt_q <= 2'h0;
         addr_q <= 8'h00;
      end else begin
         cap_cnt_q <= cap_cnt_d;
         addr_q <= addr_d;
      end
   end

   // ==========================================================
   // Power-up sequencer
   state_t state_q;
   state_t state_d;
   logic [2:0] ch_q;
   logic [2:0] ch_d;
   logic [AW-1:0] tmr_q;
   logic [AW-1:0] tmr_d;

   always_comb begin
      state_d = state_q;
      ch_d = ch_q;
      tmr_d = tmr_q;
      case (state_q)
         ST_LAMP: begin
            // Waits one step so the lamp test and capture both settle
            if (step_tick && cap_cnt_q == 2'h3) begin
               state_d = ST_RED_ON; // R3
               ch_d = 3'h0;
            end
         end
         ST_RED_ON: begin
            if (step_tick) begin
               if (ch_q == CH_LAST) begin
                  state_d = ST_RED_OFF; // R4
                  ch_d = 3'h0;
               end else begin
                  ch_d = ch_q + 3'h1;
               end
            end
         end
         ST_RED_OFF: begin
            if (step_tick) begin
               if (ch_q == CH_LAST) begin
                  state_d = ST_YEL_ON; // R5
                  ch_d = 3'h0;
               end else begin
                  ch_d = ch_q + 3'h1;
               end
            end
         end
         ST_YEL_ON: begin
            if (step_tick) begin
               if (ch_q == CH_LAST) begin
                  state_d = ST_YEL_OFF; // R5
                  ch_d = 3'h0;
               end else begin
                  ch_d = ch_q + 3'h1;
               end
            end
         end
         ST_YEL_OFF: begin
            if (step_tick) begin
               if (ch_q == CH_LAST) begin
                  state_d = ST_ADDR; // R6
                  tmr_d = '0;
               end else begin
                  ch_d = ch_q + 3'h1;
               end
            end
         end
         ST_ADDR: begin
            if (tmr_q == ADDR_LAST) begin
               state_d = ST_RUN; // R7
            end else begin
               tmr_d = tmr_q + AW'(1);
            end
         end
         ST_RUN: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_LAMP;
            ch_d = 3'h0;
            tmr_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= ST_LAMP;
         ch_q <= 3'h0;
         tmr_q <= '0;
      end else begin
         state_q <= state_d;
         ch_q <= ch_d;
         tmr_q <= tmr_d;
      end
   end

   // ==========================================================
   // Indicator and status outputs
   leds_t leds_q;
   leds_t leds_d;
   logic [7:0] fstat_q;
   logic [7:0] fstat_d;
   logic done_q;
   logic done_d;

   logic [7:0] drv_fail;
   logic [7:0] yel_steady;
   logic [7:0] yel_blink;
   logic [7:0] red_steady;
   logic [7:0] red_blink;
   logic dev_fault;

   always_comb begin
      drv_fail = ch_stat.pos_drv_fail | ch_stat.neg_drv_fail; // R11
      yel_steady = ch_stat.supv_fault | drv_fail; // R10
      yel_blink = ch_stat.not_cfg; // R16
      if (dev_stat.low_power) yel_blink = LED_ALL; // R16
      if (dev_stat.unconfigured) yel_blink = LED_ALL; // R9
      red_steady = ch_stat.active; // R15
      red_blink = LED_OFF;
      if (VARIANT == VAR_ANALOG) begin
         red_steady = ch_stat.high_alarm; // R17
         red_blink = ch_stat.low_alarm & ~ch_stat.high_alarm; // R17
         yel_steady = yel_steady | ch_stat.out_of_range; // R18
      end
      dev_fault = dev_stat.disabled | dev_stat.replace | dev_stat.watchdog_err; // R13
   end

   always_comb begin
      leds_d.power = 1'b1; // R12
      leds_d.fault = 1'b1; // R2
      leds_d.red = LED_OFF;
      leds_d.yellow = LED_OFF;
      fstat_d = yel_steady; // R10
      done_d = 1'b0;
      case (state_q)
         ST_LAMP: begin
            leds_d.fault = 1'b1; // R2
         end
         ST_RED_ON: begin
            leds_d.red = upto(ch_q); // R3
         end
         ST_RED_OFF: begin
            leds_d.red = ~upto(ch_q); // R4
         end
         ST_YEL_ON: begin
            leds_d.yellow = upto(ch_q); // R5
         end
         ST_YEL_OFF: begin
            leds_d.yellow = ~upto(ch_q); // R5
         end
         ST_ADDR: begin
            leds_d.red = addr_q; // R6
         end
         ST_RUN: begin
            // One fault pulse per power-up: lit from reset to here
            leds_d.fault = dev_fault; // R8 R14
            leds_d.red = red_steady | (red_blink & {NUM_CH{phase_q}});
            // Steady fault outranks the blink so a fault is never hidden
            leds_d.yellow = yel_steady | (yel_blink & {NUM_CH{phase_q}}); // R9
            done_d = 1'b1;
         end
         default: begin
            leds_d.fault = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         leds_q <= '{power: 1'b1, fault: 1'b1, red: LED_OFF, yellow: LED_OFF}; // R1
         fstat_q <= 8'h00;
         done_q <= 1'b0;
      end else begin
         leds_q <= leds_d;
         fstat_q <= fstat_d;
         done_q <= done_d;
      end
   end

   assign leds = leds_q;
   assign ch_fault_stat = fstat_q;
   assign pu_done = done_q;
endmodule : led_seq
`default_nettype wire

/* File: dv/led_seq_checker.sv */
// Port assertions for the status indicator sequencer
`timescale 1ns/1ps
`default_nettype none
module led_seq_checker
   import led_seq_pkg::*;
#(
   parameter variant_t VARIANT = VAR_IO
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Watched ports
   input wire logic [7:0] addr_sw,
   input wire dev_stat_t dev_stat,
   input wire ch_stat_t ch_stat,
   input wire leds_t leds,
   input wire logic [7:0] ch_fault_stat,
   input wire logic pu_done
);
   // ==========
   // History, one cycle behind like the outputs
   logic [7:0] stdy_d;
   logic [7:0] stdy_q;
   logic [7:0] act_q;
   logic [7:0] blk_q;
   logic [7:0] red_q;
   logic [7:0] yel_q;
   logic flt_q;
   logic unc_q;
   logic yel_seen_q;
   // Analog coding takes red from alarms and adds range to steady yellow
   localparam bit ANALOG = (VARIANT == VAR_ANALOG);
   always_comb begin
      stdy_d = ch_stat.supv_fault | ch_stat.pos_drv_fail | ch_stat.neg_drv_fail;
      if (ANALOG) stdy_d = stdy_d | ch_stat.out_of_range;
   end
   // Marks the yellow sweep so the address display is not taken for a red step
   always_ff @(posedge clk) begin
      if (srst) begin
         yel_seen_q <= 1'b0;
      end else if (!pu_done && leds.yellow != 8'h00) begin
         yel_seen_q <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      stdy_q <= stdy_d;
      act_q <= ANALOG ? ch_stat.high_alarm : ch_stat.active;
      blk_q <= ANALOG ? (ch_stat.low_alarm & ~ch_stat.high_alarm) : 8'h00;
      red_q <= leds.red;
      yel_q <= leds.yellow;
      flt_q <= dev_stat.disabled | dev_stat.replace | dev_stat.watchdog_err;
      unc_q <= dev_stat.unconfigured && stdy_d == 8'h00;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   chk_reset_lamps:
      assert property (disable iff (1'b0) srst |=> leds == 18'h30000 && !pu_done
         && ch_fault_stat == 8'h00) else $error("reset lamp state wrong");
   chk_power_lit:
      assert property (leds.power) else $error("power lamp off");
   chk_fault_held:
      assert property (!pu_done |-> leds.fault) else $error("fault lamp dropped early");
   chk_red_sweep:
      assert property (!pu_done && !yel_seen_q && leds.red != red_q && leds.yellow == 8'h00
         && yel_q == 8'h00
         |-> leds.red == {red_q[6:0], ~red_q[7]}) else $error("red sweep step wrong");
   chk_yellow_sweep:
      assert property (!pu_done && leds.yellow != yel_q && leds.red == 8'h00 && red_q == 8'h00
         |-> leds.yellow == {yel_q[6:0], ~yel_q[7]}) else $error("yellow sweep step wrong");
   chk_fault_follow:
      assert property (pu_done |=> leds.fault == flt_q) else $error("fault lamp mismatch");
   chk_yellow_steady:
      assert property (pu_done |=> (leds.yellow & stdy_q) == stdy_q) else $error("yellow off");
   chk_fault_stat:
      assert property (pu_done |=> ch_fault_stat == stdy_q) else $error("fault status wrong");
   chk_red_active:
      assert property (pu_done |=> (leds.red & ~blk_q) == act_q) else $error("red lamp wrong");
   chk_flash_unison:
      assert property (pu_done && $past(pu_done) && unc_q |-> leds.yellow == 8'h00
         || leds.yellow == 8'hFF) else $error("yellow flash not in unison");
   chk_red_blink:
      assert property (pu_done |=> (leds.red & blk_q) == 8'h00 || (leds.red & blk_q) == blk_q)
         else $error("red blink not in unison");
   chk_addr_steady:
      assert property (!pu_done && yel_seen_q && red_q != 8'h00 |-> leds.red == red_q)
         else $error("address display moved");
endmodule : led_seq_checker

bind led_seq led_seq_checker #(.VARIANT(VARIANT)) chk (
   .clk,
   .srst,
   .addr_sw,
   .dev_stat,
   .ch_stat,
   .leds,
   .ch_fault_stat,
   .pu_done
);
`default_nettype wire

/* File: dv/panel_model.sv */
// Front panel model: address switches and lamp counter
`timescale 1ns/1ps
`default_nettype none
module panel_model
   import led_seq_pkg::*;
#(
   parameter logic [7:0] SW_SET = 8'h96
) (
   // User disturbance
   input wire logic flip,
   // Panel side
   input wire leds_t leds,
   output logic [7:0] addr_sw,
   output logic [4:0] lamps_lit
);
   // ==========
   // Switches are plain levels; flip mimics a user after power-up
   assign addr_sw = flip ? ~SW_SET : SW_SET;
   assign lamps_lit = 5'($countones(leds));
endmodule : panel_model
`default_nettype wire

/* File: dv/led_seq_tb.sv */
// Self-checking bench for the status indicator sequencer
`timescale 1ns/1ps
`default_nettype none
module led_seq_tb
   import led_seq_pkg::*;
;
   // ==========
   // Stimulus and design
   localparam int STEP = 4;
   localparam int FL = 4;
   localparam int ADR = 16;
   localparam logic [7:0] SW = 8'h96;
   typedef struct {dev_stat_t d; logic [7:0] a, s, p, n, er, ey; logic ef;} row_t;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic flip = 1'b0;
   logic [7:0] addr_sw;
   dev_stat_t dev_stat = '0;
   ch_stat_t ch_stat = '0;
   leds_t leds;
   logic [7:0] ch_fault_stat;
   logic pu_done;
   logic [4:0] lamps_lit;
   leds_t leds_an;
   logic [7:0] fstat_an;
   logic done_an;
   logic [7:0] red_a;
   logic [7:0] exp_v;
   int bad_count = 0;
   int num_checks = 0;
   row_t rows [6];

   initial begin
      forever #2.5 clk = ~clk;
   end

   led_seq #(.VARIANT(VAR_IO), .STEP_CYCLES(STEP), .FLASH_CYCLES(FL), .ADDR_CYCLES(ADR)) dut (
      .clk(clk), .srst(srst), .addr_sw(addr_sw), .dev_stat(dev_stat), .ch_stat(ch_stat),
      .leds(leds), .ch_fault_stat(ch_fault_stat), .pu_done(pu_done));
   // Analog coding runs beside the plain one on the same stimulus
   led_seq #(.VARIANT(VAR_ANALOG), .STEP_CYCLES(STEP), .FLASH_CYCLES(FL),
      .ADDR_CYCLES(ADR)) dut_an (
      .clk(clk), .srst(srst), .addr_sw(addr_sw), .dev_stat(dev_stat), .ch_stat(ch_stat),
      .leds(leds_an), .ch_fault_stat(fstat_an), .pu_done(done_an));
   panel_model #(.SW_SET(SW)) panel (.flip(flip), .leds(leds), .addr_sw(addr_sw),
      .lamps_lit(lamps_lit));

   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   task automatic blink(input logic [7:0] mask, input logic [7:0] fix);
      logic [7:0] first;
      logic ph;
      int i;
      repeat (2) @(negedge clk);
      first = leds.yellow;
      for (i = 0; i < 3 * FL && leds.yellow === first; i++) @(negedge clk);
      if (i == 3 * FL) begin
         bad_count++;
         final_report();
      end
      ph = (leds.yellow & mask) != 8'h00;
      for (int h = 0; h < 4; h++) begin
         check("blink", 18'(leds.yellow), 18'(fix | ((ph ^ h[0]) ? mask : 8'h00)));
         repeat (FL) @(negedge clk);
      end
      $display("blink %h done", mask);
   endtask : blink

   // ==========
   // Sequence
   initial begin
      rows[0] = '{5'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0};
      rows[1] = '{5'h08, 8'hA5, 8'h00, 8'h00, 8'h00, 8'hA5, 8'h00, 1'b1};
      rows[2] = '{5'h04, 8'h00, 8'h01, 8'h10, 8'h80, 8'h00, 8'h91, 1'b1};
      rows[3] = '{5'h02, 8'h3C, 8'h02, 8'h00, 8'h00, 8'h3C, 8'h02, 1'b1};
      rows[4] = '{5'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h40, 1'b0};
      rows[5] = '{5'h00, 8'hFF, 8'h00, 8'h00, 8'h20, 8'hFF, 8'h20, 1'b0};
      repeat (16) @(negedge clk);
      check("reset leds", leds, 18'h30000);
      check("reset analog", leds_an, 18'h30000);
      check("reset done", 18'({ch_fault_stat, pu_done, done_an}), 18'h0);
      srst = 1'b0;
      for (int i = 0; leds.red !== 8'h01; i++) begin
         if (i == 20) begin
            bad_count++;
            final_report();
         end
         @(negedge clk);
      end
      exp_v = 8'h01;
      for (int k = 0; k < 32; k++) begin
         check("sweep", {leds.power, leds.fault, k < 16 ? {leds.red, leds.yellow} :
            {leds.yellow, leds.red}}, {2'b11, exp_v, 8'h00});
         if (exp_v == 8'hFF) check("lamps", 18'(lamps_lit), 18'd10);
         exp_v = (k == 15) ? 8'h01 : {exp_v[6:0], ~exp_v[7]};
         flip = (k == 2) ? 1'b1 : flip;
         repeat (STEP) @(negedge clk);
      end
      check("address", leds, {2'b11, SW, 8'h00});
      check("analog address", leds_an, {2'b11, SW, 8'h00});
      // Address stands ADDR_CYCLES cycles, so its last cycle is ADR-1 later
      repeat (ADR - 1) @(negedge clk);
      check("address held", 18'({pu_done, leds.red}), 18'({1'b0, SW}));
      @(negedge clk);
      check("run entry", 18'({pu_done, leds.fault, done_an, leds_an.fault}), 18'hA);
      $display("power-up done");
      foreach (rows[i]) begin
         dev_stat = rows[i].d;
         ch_stat = '{active: rows[i].a, supv_fault: rows[i].s, pos_drv_fail: rows[i].p,
            neg_drv_fail: rows[i].n, default: 8'h00};
         repeat (2) @(negedge clk);
         check("run", leds, {1'b1, rows[i].ef, rows[i].er, rows[i].ey});
         check("fault stat", 18'(ch_fault_stat), 18'(rows[i].ey));
         $display("row %0d done", i);
      end
      // Alarms only steer the analog coding; the plain one shows activity
      dev_stat = 5'h00;
      ch_stat = '{active: 8'hF0, high_alarm: 8'h03, low_alarm: 8'h06, out_of_range: 8'h40,
         default: 8'h00};
      repeat (2) @(negedge clk);
      red_a = leds_an.red;
      check("plain lamps", 18'({leds.red, leds.yellow}), 18'hF000);
      check("analog yellow", 18'({leds_an.yellow, fstat_an}), 18'h4040);
      check("analog red", 18'(red_a & 8'hFB), 18'h03);
      repeat (FL) @(negedge clk);
      check("analog blink", 18'(red_a ^ leds_an.red), 18'h04);
      $display("analog done");
      ch_stat = '0;
      dev_stat = 5'h10;
      blink(8'hFF, 8'h00);
      dev_stat = 5'h00;
      ch_stat = '{not_cfg: 8'h0C, supv_fault: 8'h04, default: 8'h00};
      blink(8'h08, 8'h04);
      dev_stat = 5'h01;
      ch_stat = '{supv_fault: 8'h04, default: 8'h00};
      blink(8'hFB, 8'h04);
      // Second reset mid-run: lamps restart and the switches are taken afresh
      dev_stat = 5'h00;
      ch_stat = '0;
      srst = 1'b1;
      repeat (3) @(negedge clk);
      check("mid reset leds", leds, 18'h30000);
      check("mid reset done", 18'({ch_fault_stat, pu_done, done_an}), 18'h0);
      srst = 1'b0;
      for (int i = 0; leds.red !== ~SW; i++) begin
         if (i == 200) begin
            bad_count++;
            final_report();
         end
         @(negedge clk);
      end
      check("new address", 18'({pu_done, leds.fault, leds_an.red}), 18'({2'b01, ~SW}));
      $display("mid reset done");
      final_report();
   end
endmodule : led_seq_tb
`default_nettype wire
